// *** hw/tlic_flag_cell.sv ***
// One interrupt source flag: event sets it, software writes it
module tlic_flag_cell (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic set_evt,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output logic      flag
);
    typedef struct packed {
        logic flag;
    } tlic_flag_s;

    tlic_flag_s st_reg;
    tlic_flag_s st_next;

    // Set wins over a clearing write in the same cycle
    always_comb begin
        st_next.flag = (wr_en ? wr_val : st_reg.flag) | set_evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.flag;
endmodule

// *** hw/tlic_sync.sv ***
// Two flip-flop synchroniser for asynchronous pins
module tlic_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } tlic_sync_s;

    tlic_sync_s st_reg;
    tlic_sync_s st_next;

    // First stage feeds only the second
    always_comb begin
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.s2;
endmodule

// *** hw/tlic_top.sv ***
// Two-level prioritised interrupt controller with AXI4-Lite registers
// What this block does
// - Two levels: high vector 0008h, low vector 0018h.
// - Pending enabled high request preempts a running low service.
// - Each source has a flag, an enable and a priority select.
// - Priority mode only when priority_mode_enable bit 7 set; default off.
// - In priority mode, bit 7 gates all high priority sources.
// - In priority mode, bit 6 gates all low priority sources.
// - Flag, enable and global enable set: vector by priority at once.
// - Compatibility mode ignores per-source priority selects.
// - Compatibility: bit 6 gates peripherals, bit 7 gates every source.
// - Compatibility mode always vectors to 0008h.
// - Accepting an interrupt clears the relevant global enable.
// - No low service while a high service runs.
// - On accept the core pushes return address and loads the vector.
// - Return from interrupt leaves the current level and sets that level's enable again.
// - External events reach the vector in four to five cycles.
// - Flags set on events regardless of any enable, for polling.
// - Control registers are readable and writable by software.
module tlic_top
    import tlic_pkg::*;
#(
    parameter int unsigned NUM_EXT = 4,
    parameter int unsigned NUM_PER = 4
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite slave
    input  wire logic [tlic_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [tlic_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [tlic_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [tlic_pkg::DATA_W-1:0]     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Interrupt sources
    input  wire logic [NUM_EXT-1:0]         ext_irq_pin,
    input  wire logic [NUM_PER-1:0]         periph_event,
    // Processor core side
    output logic                            core_irq_req,
    output logic                            core_irq_high,
    output logic [tlic_pkg::VEC_W-1:0]      core_irq_vector,
    input  wire logic                       core_irq_ack,
    input  wire logic                       core_return_from_irq_instr
);
    import tlic_pkg::*;

    localparam int unsigned NUM_SRC = NUM_EXT + NUM_PER;

    typedef struct packed {
        logic               aw_held;
        logic [ADDR_W-1:0]  aw_addr;
        logic               w_held;
        logic [REG_W-1:0]   w_data;
        logic               w_lane0;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [REG_W-1:0]   rdata;
        logic [1:0]         rresp;
        logic [REG_W-1:0]   ctl;
        logic               prio_mode;
        logic [NUM_SRC-1:0] enable;
        logic [NUM_SRC-1:0] prio;
        logic [NUM_EXT-1:0] edge_rise;
        logic [NUM_EXT-1:0] pin_prev;
        tlic_svc_e          svc;
        logic               req;
        logic               req_high;
        logic [VEC_W-1:0]   vec;
    } tlic_top_s;

    tlic_top_s st_reg;
    tlic_top_s st_next;

    logic [NUM_EXT-1:0] pin_sync;
    logic [NUM_EXT-1:0] pin_edge;
    logic [NUM_SRC-1:0] src_evt;
    logic [NUM_SRC-1:0] flags;
    logic [NUM_SRC-1:0] periph_mask;
    logic [NUM_SRC-1:0] armed;
    logic               wr_fire;
    logic               flag_wr;
    logic               ack_fire;
    logic               pend_high;
    logic               pend_low;
    logic               pend_any;
    logic [REG_W-1:0]   rd_mux;
    logic               rd_hit;
    logic               wr_hit;

    // Pins cross into the clock domain before edge detection
    tlic_sync #(
        .WIDTH (NUM_EXT)
    ) u_pin_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (ext_irq_pin),
        .sync_out (pin_sync)
    );

    // Edge select per pin: rising when set, falling when clear
    assign pin_edge = (pin_sync & ~st_reg.pin_prev & st_reg.edge_rise)
                    | (~pin_sync & st_reg.pin_prev & ~st_reg.edge_rise);
    assign src_evt  = {periph_event, pin_edge};
    assign periph_mask = {{NUM_PER{1'b1}}, {NUM_EXT{1'b0}}};

    // Write is performed once address and data are both held
    assign wr_fire = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
    assign flag_wr = wr_fire & st_reg.w_lane0 & (st_reg.aw_addr == OFS_FLAG);

    // One flag per source, set by its event or by a write to the flag register
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_flag
        tlic_flag_cell u_flag (
            .aclk    (aclk),
            .aresetn (aresetn),
            .set_evt (src_evt[i]),
            .wr_en   (flag_wr),
            .wr_val  (st_reg.w_data[i]),
            .flag    (flags[i])
        );
    end

    // A source asks only when flag and enable are both set
    assign armed = flags & st_reg.enable;

    // Pending requests per level and mode
    always_comb begin
        pend_high = 1'b0;
        pend_low  = 1'b0;
        if (st_reg.prio_mode) begin
            pend_high = (|(armed & st_reg.prio))
                      & st_reg.ctl[CTL_GIE_BIT];
            pend_low  = (|(armed & ~st_reg.prio))
                      & st_reg.ctl[CTL_PERIPHERAL_IRQ_ENABLE_BIT]
                      & (st_reg.svc == TLIC_IDLE);
        end else begin
            // Priority selects play no part here
            pend_high = st_reg.ctl[CTL_GIE_BIT]
                      & ((|(armed & ~periph_mask))
                      | ((|(armed & periph_mask))
                      & st_reg.ctl[CTL_PERIPHERAL_IRQ_ENABLE_BIT]));
        end
        pend_any = pend_high | pend_low;
    end

    assign ack_fire = st_reg.req & core_irq_ack;

    // Read data for the addressed register
    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_IRQ_CTL: rd_mux = st_reg.ctl;
            OFS_RST_CTL: rd_mux[RST_PME_BIT] = st_reg.prio_mode;
            OFS_FLAG:    rd_mux[NUM_SRC-1:0] = flags;
            OFS_ENABLE:  rd_mux[NUM_SRC-1:0] = st_reg.enable;
            OFS_PRIO:    rd_mux[NUM_SRC-1:0] = st_reg.prio;
            OFS_EDGE:    rd_mux[NUM_EXT-1:0] = st_reg.edge_rise;
            OFS_STATUS: begin
                rd_mux[STAT_SVC_LSB +: 2] = st_reg.svc;
                rd_mux[STAT_REQ_BIT]      = st_reg.req;
            end
            default:     rd_hit = 1'b0;
        endcase
    end

    // Address decode for the held write
    always_comb begin
        unique case (st_reg.aw_addr)
            OFS_IRQ_CTL, OFS_RST_CTL, OFS_FLAG, OFS_ENABLE,
            OFS_PRIO, OFS_EDGE, OFS_STATUS: wr_hit = 1'b1;
            default:                        wr_hit = 1'b0;
        endcase
    end

    // Next state of bus slave, registers and service nesting
    always_comb begin
        st_next = st_reg;
        st_next.pin_prev = pin_sync;

        // Write address and data are taken independently
        if (s_axi_awvalid && !st_reg.aw_held) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_held) begin
            st_next.w_held  = 1'b1;
            st_next.w_data  = s_axi_wdata[REG_W-1:0];
            st_next.w_lane0 = s_axi_wstrb[0];
        end

        // Register write; only byte lane 0 carries data
        if (wr_fire) begin
            st_next.bvalid = 1'b1;
            st_next.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (st_reg.w_lane0) begin
                unique case (st_reg.aw_addr)
                    OFS_IRQ_CTL: st_next.ctl = st_reg.w_data;
                    OFS_RST_CTL: st_next.prio_mode = st_reg.w_data[RST_PME_BIT];
                    OFS_ENABLE:  st_next.enable = st_reg.w_data[NUM_SRC-1:0];
                    OFS_PRIO:    st_next.prio = st_reg.w_data[NUM_SRC-1:0];
                    OFS_EDGE:    st_next.edge_rise = st_reg.w_data[NUM_EXT-1:0];
                    default:     st_next.bvalid = 1'b1;
                endcase
            end
        end

        // Response releases both holding stages
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid  = 1'b0;
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
        end

        // Read answers one cycle after the address is taken
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_mux;
            st_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // Acceptance clears the enable of the level taken, after any write
        if (ack_fire) begin
            if (st_reg.req_high) begin
                st_next.ctl[CTL_GIE_BIT] = 1'b0;
                // Nest over a running low service
                st_next.svc = (st_reg.svc == TLIC_LOW) ? TLIC_LOW_HIGH
                                                       : TLIC_HIGH;
            end else begin
                st_next.ctl[CTL_PERIPHERAL_IRQ_ENABLE_BIT] = 1'b0;
                st_next.svc = TLIC_LOW;
            end
        end else if (core_return_from_irq_instr) begin
            // Return restores the enable of the level being left
            unique case (st_reg.svc)
                TLIC_HIGH: begin
                    st_next.ctl[CTL_GIE_BIT] = 1'b1;
                    st_next.svc = TLIC_IDLE;
                end
                TLIC_LOW_HIGH: begin
                    st_next.ctl[CTL_GIE_BIT] = 1'b1;
                    st_next.svc = TLIC_LOW;
                end
                TLIC_LOW: begin
                    st_next.ctl[CTL_PERIPHERAL_IRQ_ENABLE_BIT] = 1'b1;
                    st_next.svc = TLIC_IDLE;
                end
                TLIC_IDLE: st_next.svc = TLIC_IDLE;
            endcase
        end

        // Request is dropped in the accept cycle so it cannot be taken twice
        st_next.req      = pend_any & ~ack_fire;
        st_next.req_high = pend_high;
        st_next.vec      = (pend_high || !st_reg.prio_mode)
                         ? VEC_HIGH : VEC_LOW;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg           <= '0;
            st_reg.ctl       <= CTL_RST;
            st_reg.enable    <= EN_RST[NUM_SRC-1:0];
            st_reg.prio      <= PRIO_RST[NUM_SRC-1:0];
            st_reg.edge_rise <= EDGE_RST[NUM_EXT-1:0];
            st_reg.svc       <= TLIC_IDLE;
            st_reg.vec       <= VEC_HIGH;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus outputs
    assign s_axi_awready = ~st_reg.aw_held;
    assign s_axi_wready  = ~st_reg.w_held;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = ~st_reg.rvalid;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rresp   = st_reg.rresp;
    assign s_axi_rdata   = {{(DATA_W-REG_W){1'b0}}, st_reg.rdata};

    // Core side: the core pushes its return address and jumps here
    assign core_irq_req    = st_reg.req;
    assign core_irq_high   = st_reg.req_high;
    assign core_irq_vector = st_reg.vec;
endmodule

// *** pkg/tlic_pkg.sv ***
// Constants, register map and types of the two-level interrupt controller
package tlic_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned VEC_W  = 16;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RST_CTL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_FLAG    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_PRIO    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EDGE    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;

    // Field positions
    localparam int unsigned CTL_GIE_BIT   = 7;
    localparam int unsigned CTL_PERIPHERAL_IRQ_ENABLE_BIT  = 6;
    localparam int unsigned RST_PME_BIT   = 7;
    localparam int unsigned STAT_REQ_BIT  = 2;
    localparam int unsigned STAT_SVC_LSB  = 0;

    // Reset values
    localparam logic [REG_W-1:0] CTL_RST  = 8'h00;
    localparam logic [REG_W-1:0] EN_RST   = 8'h00;
    localparam logic [REG_W-1:0] PRIO_RST = 8'hff;
    localparam logic [REG_W-1:0] EDGE_RST = 8'hff;

    // Vector addresses
    localparam logic [VEC_W-1:0] VEC_HIGH = 16'h0008;
    localparam logic [VEC_W-1:0] VEC_LOW  = 16'h0018;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Service nesting, Gray coded along idle, low, low+high, high
    typedef enum logic [1:0] {
        TLIC_IDLE     = 2'h0,
        TLIC_LOW      = 2'h1,
        TLIC_LOW_HIGH = 2'h3,
        TLIC_HIGH     = 2'h2
    } tlic_svc_e;
endpackage

// *** testbench/tlic_core_model.sv ***
// Behavioural processor core that accepts requests and returns from service
module tlic_core_model
    import tlic_pkg::*;
(
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       core_irq_req,
    input  wire logic [tlic_pkg::VEC_W-1:0] core_irq_vector,
    input  wire logic                       ack_en,
    input  wire logic [3:0]                 ack_wait,
    input  wire logic                       ret_req,
    output logic                            core_irq_ack,
    output logic                            core_return_from_irq_instr,
    output logic [3:0]                      depth,
    output logic [tlic_pkg::VEC_W-1:0]      last_vec
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;

    // Return has priority so a bench request is never lost to a new ack
    always @(posedge aclk) begin
        core_irq_ack <= 1'b0;
        core_return_from_irq_instr  <= 1'b0;
        if (!aresetn) begin
            depth    <= 4'h0;
            wait_cnt <= 4'h0;
        end else if (ret_req && depth != 4'h0) begin
            core_return_from_irq_instr <= 1'b1;
            depth       <= depth - 4'h1;
        end else if (core_irq_req && ack_en && !core_irq_ack) begin
            if (wait_cnt == ack_wait) begin
                core_irq_ack <= 1'b1;
                last_vec     <= core_irq_vector;
                depth        <= depth + 4'h1; // Push of the return point
                wait_cnt     <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end
    end
endmodule

// *** testbench/tlic_props.sv ***
// Port-level property checker for the interrupt controller, bound into the top
module tlic_props
    import tlic_pkg::*;
(
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_wvalid,
    input wire logic                        s_axi_wready,
    input wire logic [1:0]                  s_axi_bresp,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic [tlic_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_rready,
    input wire logic                        core_irq_req,
    input wire logic                        core_irq_high,
    input wire logic [tlic_pkg::VEC_W-1:0]  core_irq_vector,
    input wire logic                        core_irq_ack
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Handshake steps used by several properties
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ack_take;
        core_irq_req && core_irq_ack;
    endsequence

    // Bus answers: response lands exactly two cycles after the write is taken
    wr_resp_time_a:
        assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response timing wrong");
    rd_resp_time_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data not next cycle");
    rd_data_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    wr_resp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    ar_ready_tie_a:
        assert property (s_axi_arready == !s_axi_rvalid) else $error("arready not inverse of rvalid");
    wr_block_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");

    // Core link: acceptance withdraws the request, vector follows the level
    ack_drop_a:
        assert property (ack_take |=> !core_irq_req) else $error("request stands after acceptance");
    vec_high_a:
        assert property (core_irq_req && core_irq_high |-> core_irq_vector == VEC_HIGH)
        else $error("high request with wrong vector");
    vec_low_a:
        assert property (core_irq_req && !core_irq_high |-> core_irq_vector == VEC_LOW)
        else $error("low request with wrong vector");
endmodule

bind tlic_top tlic_props u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .core_irq_req(core_irq_req), .core_irq_high(core_irq_high),
    .core_irq_vector(core_irq_vector), .core_irq_ack(core_irq_ack)
);

// *** testbench/tlic_top_tb.sv ***
// Self-checking bench for the two-level interrupt controller
module tlic_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tlic_pkg::*;
    logic                aclk = 1'b0;
    logic                aresetn = 1'b0;
    logic [ADDR_W-1:0]   awaddr = 8'h00, araddr = 8'h00;
    logic [DATA_W-1:0]   wdata = 32'h0, rdata;
    logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                awready, wready, bvalid, arready, rvalid, req, high, ack, ret;
    logic [1:0]          bresp, rresp;
    logic [3:0]          pins = 4'h0, pevt = 4'h0, ack_wait = 4'h3, depth;
    logic                ack_en = 1'b1, ret_req = 1'b0;
    logic [VEC_W-1:0]    vec, last_vec;
    // Edge select holds one bit per pin only, so its upper bits read as zero
    logic [7:0]          rst_tab [7] = '{CTL_RST, 8'h00, 8'h00, EN_RST, PRIO_RST, EDGE_RST & 8'h0f, 8'h00};
    int                  error_cnt = 0, total_checks = 0, n;

    always #4 aclk = ~aclk;

    tlic_top DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_irq_pin(pins), .periph_event(pevt), .core_irq_req(req), .core_irq_high(high),
        .core_irq_vector(vec), .core_irq_ack(ack), .core_return_from_irq_instr(ret)
    );
    tlic_core_model u_core (
        .aclk(aclk), .aresetn(aresetn), .core_irq_req(req), .core_irq_vector(vec), .ack_en(ack_en),
        .ack_wait(ack_wait), .ret_req(ret_req), .core_irq_ack(ack), .core_return_from_irq_instr(ret), .depth(depth),
        .last_vec(last_vec)
    );

    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A hung wait counts as a mismatch and closes the run
    task automatic expire(input int k);
        if (k >= 200) begin
            check(32'h0, 32'h1);
            wrap_up();
        end
    endtask

    // Ready for the answer is raised late so the hold of the answer gets exercised
    // One word per call, never a two-register move while enabled
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            expire(k);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            expire(k);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        check(rdata, {24'h0, ed});
        check({30'h0, rresp}, {30'h0, er});
    endtask

    task automatic wait_req(output int k);
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            expire(k);
        end while (!req);
    endtask

    task automatic wait_depth(input logic [3:0] d);
        int k;
        k = 0;
        while (depth !== d) begin
            @(posedge aclk);
            k++;
            expire(k);
        end
    endtask

    task automatic do_ret();
        @(posedge aclk);
        ret_req <= 1'b1;
        @(posedge aclk);
        ret_req <= 1'b0;
    endtask

    // Main sequence: reset map, polling, compatibility mode, then priority mode
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) axi_rd(8'(4 * i), rst_tab[i], RESP_OKAY);
        axi_rd(8'h1c, 8'h00, RESP_SLVERR);
        axi_wr(8'h1c, 8'h5a, RESP_SLVERR);
        pevt <= 4'h1;
        @(posedge aclk);
        pevt <= 4'h0;
        axi_rd(OFS_FLAG, 8'h10, RESP_OKAY);
        axi_wr(OFS_ENABLE, 8'h11, RESP_OKAY);
        axi_rd(OFS_ENABLE, 8'h11, RESP_OKAY);
        axi_wr(OFS_PRIO, 8'h00, RESP_OKAY);
        axi_wr(OFS_IRQ_CTL, 8'h80, RESP_OKAY);
        check({31'h0, req}, 32'h0);
        pins <= 4'h1;
        wait_req(n);
        check(32'(n == 4 || n == 5), 32'h1);
        pins <= 4'h0;
        wait_depth(4'h1);
        check({16'h0, last_vec}, {16'h0, VEC_HIGH});
        axi_rd(OFS_IRQ_CTL, 8'h00, RESP_OKAY);
        axi_wr(OFS_FLAG, 8'h10, RESP_OKAY);
        do_ret();
        axi_rd(OFS_IRQ_CTL, 8'h80, RESP_OKAY);
        axi_wr(OFS_IRQ_CTL, 8'hc0, RESP_OKAY);
        wait_depth(4'h1);
        check({16'h0, last_vec}, {16'h0, VEC_HIGH});
        axi_wr(OFS_FLAG, 8'h00, RESP_OKAY);
        do_ret();
        axi_wr(OFS_RST_CTL, 8'h80, RESP_OKAY);
        axi_wr(OFS_PRIO, 8'h01, RESP_OKAY);
        // Flags were cleared above before the sources are enabled
        axi_wr(OFS_ENABLE, 8'h03, RESP_OKAY);
        ack_en   <= 1'b0;
        ack_wait <= 4'h0;
        pins     <= 4'h3;
        wait_req(n);
        pins <= 4'h0;
        repeat (2) @(posedge aclk);
        check({high, vec}, {1'b1, VEC_HIGH});
        ack_en <= 1'b1;
        wait_depth(4'h1);
        axi_rd(OFS_IRQ_CTL, 8'h40, RESP_OKAY);
        check({28'h0, depth}, 32'h1);
        axi_wr(OFS_FLAG, 8'h02, RESP_OKAY);
        do_ret();
        wait_depth(4'h0);
        wait_depth(4'h1);
        check({16'h0, last_vec}, {16'h0, VEC_LOW});
        axi_rd(OFS_IRQ_CTL, 8'h80, RESP_OKAY);
        pins <= 4'h1;
        wait_depth(4'h2);
        check({16'h0, last_vec}, {16'h0, VEC_HIGH});
        axi_rd(OFS_STATUS, 8'h03, RESP_OKAY);
        wrap_up();
    end
endmodule
